// ===== core/sfr_defs.svh
/*
 Constants for the supply fault response and retry block: command codes,
 field positions, reset values and timing figures.
 Assumes inclusion by bare name from the package and the core.
*/
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH
`define SFR_CMD_CLEAR   8'h03
`define SFR_CMD_OT      8'h50
`define SFR_CMD_UT      8'h54
`define SFR_CMD_VIN_OV  8'h56
`define SFR_CMD_VIN_UV  8'h5A
`define SFR_CMD_TON     8'h63
`define SFR_CMD_RDELAY  8'hDB
`define SFR_CMD_RCOUNT  8'hF7
`define SFR_ACT_MSB     7
`define SFR_ACT_LSB     6
`define SFR_RTRY_MSB    5
`define SFR_RTRY_LSB    3
`define SFR_DLY_MSB     2
`define SFR_ACT_RST     8'h00
`define SFR_RDELAY_RST  16'hF320
`define SFR_RCOUNT_RST  3'h0
`define SFR_RETRY_INF   3'h7
`define SFR_CLK_HZ      32'h0EE6_B280
`define SFR_CLEAR_S     8'h10
`define SFR_CAP_US      32'h00C7_E3E0
`define SFR_STEP_US     16'h00C8
`define SFR_US_PER_MS   16'h03E8
`endif

// ===== core/sfr_pkg.sv
/*
 Types for the supply fault response and retry block.
 Assumes the constants header sits beside it.
*/
`include "sfr_defs.svh"
package sfr_pkg;
	typedef enum logic [4:0] {
		SFR_ON     = 5'h01,
		SFR_SEQOFF = 5'h02,
		SFR_WAIT   = 5'h04,
		SFR_LATCH  = 5'h08,
		SFR_OFF    = 5'h10
	} sfr_chst_t;

	typedef struct packed {
		sfr_chst_t   st;
		logic        trk;
		logic [2:0]  rtry;
		logic [31:0] toff;
		logic [2:0]  used;
		logic [31:0] quiet;
		logic [15:0] units;
		logic        req_tg;
		logic        done_s1;
		logic        done_s2;
		logic        ctl_s1;
		logic        ctl_s2;
		logic        prev_on;
		logic        en;
		logic        st_ot;
		logic        st_ut;
		logic        st_ton;
	} sfr_ch_t;

	typedef struct packed {
		logic        req_s1;
		logic        req_s2;
		logic        seen;
		logic        ack_tg;
		logic [15:0] pre;
		logic [15:0] left;
	} sfr_sh_t;
endpackage

// ===== core/sfr_core.sv
/*
 Fault response and restart sequencing for NCH supply channels, the
 five response bytes, retry interval and count, status bits and alert.
 Assumes fault strobes, operation state and tracking come from logic on
 mclk_in; control pins and bias come asynchronously; share_clk_in is the
 shared timing clock of the power system.
*/
//
// How it works
// - Measured temperature or input fault sets summary, detail bits and alert.
// - Action 00b leaves the channel running untouched.
// - Action 01b-11b shuts down or sequences off, then applies retry.
// - Retry 000b never restarts; output stays off until cleared.
// - Nonzero retry restarts up to count; stops on off, bias, new fault.
// - New retry settings may wait for next off-then-on sequence.
// - Start-up timeout sets high byte, vout and timeout bits and alert in one cycle.
// - Retry interval is timed only from the shared clock.
// - Retry interval is capped at 13.1 seconds.
// - Retry interval is rounded to nearest 200 us.
// - Retry interval read returns last written value.
// - Count 0 none, 1-6 that many, 7 unlimited; each channel counts its own.
// - Retry counter clears after 16 s unfaulted or off-then-on.
// - Clear command resets status and alert, not faulted-off state.
// - Latched faults clear on pin toggle, operation off or bias loss.
`timescale 1ns/1ps
`include "sfr_defs.svh"
module sfr_core
	import sfr_pkg::*;
#(
	parameter int          NCH          = 2,
	parameter logic [31:0] TOFF_CYCLES  = 32'h0000_0010,
	parameter logic [15:0] SHARE_PER_STEP = 16'h0014,
	parameter logic [31:0] CLEAR_CYCLES =
		32'(64'(`SFR_CLEAR_S) * 64'(`SFR_CLK_HZ))
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_in,
	input  wire logic             share_clk_in,
	input  wire logic             cmd_valid_in,
	input  wire logic             cmd_write_in,
	input  wire logic [7:0]       cmd_code_in,
	input  wire logic [15:0]      cmd_wdata_in,
	input  wire logic [NCH-1:0]   control_pin_in,
	input  wire logic             bias_ok_in,
	input  wire logic [NCH-1:0]   op_on_in,
	input  wire logic [NCH-1:0]   track_en_in,
	input  wire logic [NCH-1:0]   ot_fault_in,
	input  wire logic [NCH-1:0]   ut_fault_in,
	input  wire logic             vin_ov_fault_in,
	input  wire logic             vin_uv_fault_in,
	input  wire logic [NCH-1:0]   ton_max_fault_in,
	output logic [15:0]           cmd_rdata_out,
	output logic                  cmd_rvalid_out,
	output logic [NCH-1:0]        chan_en_out,
	output logic [NCH-1:0]        st_ot_out,
	output logic [NCH-1:0]        st_ut_out,
	output logic [NCH-1:0]        st_ton_max_out,
	output logic                  st_vin_ov_out,
	output logic                  st_vin_uv_out,
	output logic                  sum_temp_out,
	output logic                  sum_input_out,
	output logic                  sum_vout_out,
	output logic                  sum_high_out,
	output logic                  host_alert_n_out
);
	localparam logic [31:0] CAP_UNITS = `SFR_CAP_US / 32'(`SFR_STEP_US);
	localparam logic [63:0] MS_FACTOR =
		64'(`SFR_US_PER_MS / `SFR_STEP_US);

	typedef struct packed {
		sfr_ch_t [NCH-1:0] ch;
		logic [7:0]        ot_act;
		logic [7:0]        ut_act;
		logic [7:0]        vov_act;
		logic [7:0]        vuv_act;
		logic [7:0]        ton_act;
		logic [15:0]       rdelay;
		logic [2:0]        rcount;
		logic              bias_s1;
		logic              bias_s2;
		logic              st_vov;
		logic              st_vuv;
		logic [15:0]       rdata;
		logic              rvalid;
		logic              sum_temp;
		logic              sum_in;
		logic              sum_vout;
		logic              sum_high;
		logic              alert_n;
	} sfr_main_t;

	typedef struct packed {
		sfr_sh_t [NCH-1:0] ch;
		logic              rst_s1;
		logic              rst_s2;
	} sfr_share_t;

	sfr_main_t  q;
	sfr_main_t  d;
	sfr_share_t sq;
	sfr_share_t sd;

	// Interval word to 200 us steps
	function automatic logic [15:0] l11_units(input logic [15:0] w);
		logic [63:0] v;
		logic [4:0]  sh;
		v = 64'(w[9:0]) * MS_FACTOR;
		sh = 5'd0;
		if (w[10]) begin
			v = 64'd0;
		end else if (!w[15]) begin
			v = v << w[14:11];
		end else begin
			sh = (~w[15:11]) + 5'd1;
			v = (v + (64'd1 << (sh - 5'd1))) >> sh;
		end
		if (v > 64'(CAP_UNITS)) begin
			v = 64'(CAP_UNITS);
		end
		return v[15:0];
	endfunction

	always_comb begin
		sfr_ch_t    c;
		logic       wr;
		logic       clr;
		logic       on;
		logic       trip;
		logic [7:0] sel;
		logic       allow;
		logic       any_ot;
		logic       any_ut;
		logic       any_ton;
		c = '0;
		d = q;
		wr = cmd_valid_in & cmd_write_in;
		clr = wr & (cmd_code_in == `SFR_CMD_CLEAR);
		on = 1'b0;
		trip = 1'b0;
		sel = 8'h00;
		allow = 1'b0;
		any_ot = 1'b0;
		any_ut = 1'b0;
		any_ton = 1'b0;
		d.bias_s1 = bias_ok_in;
		d.bias_s2 = q.bias_s1;
		if (wr) begin
			case (cmd_code_in)
				`SFR_CMD_OT:     d.ot_act  = {cmd_wdata_in[7:3], 3'h0};
				`SFR_CMD_UT:     d.ut_act  = {cmd_wdata_in[7:3], 3'h0};
				`SFR_CMD_VIN_OV: d.vov_act = {cmd_wdata_in[7:3], 3'h0};
				`SFR_CMD_VIN_UV: d.vuv_act = {cmd_wdata_in[7:3], 3'h0};
				`SFR_CMD_TON:    d.ton_act = {cmd_wdata_in[7:3], 3'h0};
				`SFR_CMD_RDELAY: d.rdelay  = cmd_wdata_in;
				`SFR_CMD_RCOUNT: d.rcount  = cmd_wdata_in[2:0];
				default: d.rcount = q.rcount;
			endcase
		end
		d.rvalid = cmd_valid_in & !cmd_write_in;
		case (cmd_code_in)
			`SFR_CMD_OT:     d.rdata = {8'h00, q.ot_act};
			`SFR_CMD_UT:     d.rdata = {8'h00, q.ut_act};
			`SFR_CMD_VIN_OV: d.rdata = {8'h00, q.vov_act};
			`SFR_CMD_VIN_UV: d.rdata = {8'h00, q.vuv_act};
			`SFR_CMD_TON:    d.rdata = {8'h00, q.ton_act};
			`SFR_CMD_RDELAY: d.rdata = q.rdelay;
			`SFR_CMD_RCOUNT: d.rdata = {13'h0000, q.rcount};
			default:         d.rdata = 16'h0000;
		endcase
		d.st_vov = (q.st_vov & !clr) | vin_ov_fault_in;
		d.st_vuv = (q.st_vuv & !clr) | vin_uv_fault_in;
		for (int i = 0; i < NCH; i++) begin
			c = q.ch[i];
			c.ctl_s1 = control_pin_in[i];
			c.ctl_s2 = q.ch[i].ctl_s1;
			c.done_s1 = sq.ch[i].ack_tg;
			c.done_s2 = q.ch[i].done_s1;
			// Off by pin, operation or bias
			on = q.ch[i].ctl_s2 & op_on_in[i] & q.bias_s2;
			c.prev_on = on;
			c.st_ot = (q.ch[i].st_ot & !clr) | ot_fault_in[i];
			c.st_ut = (q.ch[i].st_ut & !clr) | ut_fault_in[i];
			c.st_ton = (q.ch[i].st_ton & !clr) | ton_max_fault_in[i];
			trip = 1'b1;
			if (ot_fault_in[i] && q.ot_act[7:6] != 2'b00) begin
				sel = q.ot_act;
			end else if (ut_fault_in[i] && q.ut_act[7:6] != 2'b00) begin
				sel = q.ut_act;
			end else if (vin_ov_fault_in && q.vov_act[7:6] != 2'b00) begin
				sel = q.vov_act;
			end else if (vin_uv_fault_in && q.vuv_act[7:6] != 2'b00) begin
				sel = q.vuv_act;
			end else if (ton_max_fault_in[i] &&
					q.ton_act[7:6] != 2'b00) begin
				sel = q.ton_act;
			end else begin
				trip = 1'b0;
				sel = 8'h00;
			end
			allow = (q.ch[i].rtry != 3'h0) &&
				((q.rcount == `SFR_RETRY_INF) || (q.ch[i].used < q.rcount));
			if (q.ch[i].st == SFR_ON) begin
				if (q.ch[i].quiet >= CLEAR_CYCLES - 32'd1) begin
					c.used = 3'h0;
				end else begin
					c.quiet = q.ch[i].quiet + 32'd1;
				end
			end else begin
				c.quiet = 32'd0;
			end
			unique case (q.ch[i].st)
				SFR_ON: begin
					if (!on) begin
						c.st = SFR_OFF;
					end else if (trip) begin
						c.st = SFR_SEQOFF;
						c.trk = track_en_in[i];
						c.rtry = sel[`SFR_RTRY_MSB:`SFR_RTRY_LSB];
						c.toff = 32'd0;
					end
				end
				SFR_SEQOFF: begin
					if (!on) begin
						c.st = SFR_OFF;
					end else if (!q.ch[i].trk ||
							q.ch[i].toff >= TOFF_CYCLES - 32'd1) begin
						if (allow) begin
							c.st = SFR_WAIT;
							c.units = l11_units(q.rdelay);
							c.req_tg = !q.ch[i].req_tg;
						end else begin
							c.st = SFR_LATCH;
						end
					end else begin
						c.toff = q.ch[i].toff + 32'd1;
					end
				end
				SFR_WAIT: begin
					// Retry ends on off or fresh fault
					if (!on) begin
						c.st = SFR_OFF;
					end else if (trip) begin
						c.st = SFR_LATCH;
					end else if (q.ch[i].done_s2 == q.ch[i].req_tg) begin
						c.st = SFR_ON;
						if (q.rcount != `SFR_RETRY_INF) begin
							c.used = q.ch[i].used + 3'h1;
						end
					end
				end
				SFR_LATCH: begin
					if (!on) begin
						c.st = SFR_OFF;
					end
				end
				SFR_OFF: begin
					c.used = 3'h0;
					if (on) begin
						c.st = SFR_ON;
					end
				end
			endcase
			c.en = (c.st == SFR_ON) || (c.st == SFR_SEQOFF && c.trk);
			d.ch[i] = c;
			any_ot = any_ot | c.st_ot;
			any_ut = any_ut | c.st_ut;
			any_ton = any_ton | c.st_ton;
		end
		d.sum_temp = any_ot | any_ut;
		d.sum_in = d.st_vov | d.st_vuv;
		d.sum_vout = any_ton;
		d.sum_high = any_ton | d.sum_in;
		d.alert_n = !(d.sum_temp | d.sum_in | any_ton);
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			q <= '0;
			q.ot_act <= `SFR_ACT_RST;
			q.ut_act <= `SFR_ACT_RST;
			q.vov_act <= `SFR_ACT_RST;
			q.vuv_act <= `SFR_ACT_RST;
			q.ton_act <= `SFR_ACT_RST;
			q.rdelay <= `SFR_RDELAY_RST;
			q.rcount <= `SFR_RCOUNT_RST;
			q.alert_n <= 1'b1;
			for (int i = 0; i < NCH; i++) begin
				q.ch[i].st <= SFR_OFF;
			end
		end else begin
			q <= d;
		end
	end

	always_comb begin
		sd = sq;
		sd.rst_s1 = rst_in;
		sd.rst_s2 = sq.rst_s1;
		for (int i = 0; i < NCH; i++) begin
			sd.ch[i].req_s1 = q.ch[i].req_tg;
			sd.ch[i].req_s2 = sq.ch[i].req_s1;
			if (sq.ch[i].req_s2 != sq.ch[i].seen) begin
				sd.ch[i].seen = sq.ch[i].req_s2;
				sd.ch[i].left = q.ch[i].units;
				sd.ch[i].pre = 16'h0000;
			end else if (sq.ch[i].seen != sq.ch[i].ack_tg) begin
				if (sq.ch[i].left == 16'h0000) begin
					sd.ch[i].ack_tg = sq.ch[i].seen;
				end else if (sq.ch[i].pre >= SHARE_PER_STEP - 16'h0001) begin
					sd.ch[i].pre = 16'h0000;
					sd.ch[i].left = sq.ch[i].left - 16'h0001;
				end else begin
					sd.ch[i].pre = sq.ch[i].pre + 16'h0001;
				end
			end
			if (sq.rst_s2) begin
				sd.ch[i] = '0;
			end
		end
	end

	always_ff @(posedge share_clk_in) begin
		sq <= sd;
	end

	assign cmd_rdata_out = q.rdata;
	assign cmd_rvalid_out = q.rvalid;
	assign st_vin_ov_out = q.st_vov;
	assign st_vin_uv_out = q.st_vuv;
	assign sum_temp_out = q.sum_temp;
	assign sum_input_out = q.sum_in;
	assign sum_vout_out = q.sum_vout;
	assign sum_high_out = q.sum_high;
	assign host_alert_n_out = q.alert_n;

	generate
		for (genvar g = 0; g < NCH; g++) begin : g_out
			assign chan_en_out[g] = q.ch[g].en;
			assign st_ot_out[g] = q.ch[g].st_ot;
			assign st_ut_out[g] = q.ch[g].st_ut;
			assign st_ton_max_out[g] = q.ch[g].st_ton;
		end
	endgenerate
endmodule

// ===== testbench/sfr_core_props.sv
/*
 Port checker for the fault response core.
 Assumes a bind onto every core instance.
*/
`timescale 1ns/1ps
module sfr_core_props
	import sfr_pkg::*;
#(
	parameter int NCH = 2
) (
	input wire logic           mclk_in,
	input wire logic           rst_in,
	input wire logic           cmd_valid_in,
	input wire logic           cmd_write_in,
	input wire logic [7:0]     cmd_code_in,
	input wire logic [NCH-1:0] ot_fault_in,
	input wire logic [NCH-1:0] ut_fault_in,
	input wire logic           vin_ov_fault_in,
	input wire logic           vin_uv_fault_in,
	input wire logic [NCH-1:0] ton_max_fault_in,
	input wire logic           cmd_rvalid_out,
	input wire logic [NCH-1:0] st_ot_out,
	input wire logic [NCH-1:0] st_ut_out,
	input wire logic [NCH-1:0] st_ton_max_out,
	input wire logic           st_vin_ov_out,
	input wire logic           st_vin_uv_out,
	input wire logic           sum_temp_out,
	input wire logic           sum_input_out,
	input wire logic           sum_vout_out,
	input wire logic           sum_high_out,
	input wire logic           host_alert_n_out
);
	wire logic any_f;
	wire logic rd_req;
	assign any_f = |{ot_fault_in, ut_fault_in, vin_ov_fault_in,
		vin_uv_fault_in, ton_max_fault_in};
	assign rd_req = cmd_valid_in & ~cmd_write_in;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	a_alert_level: assert property (
		host_alert_n_out == !(|{st_ot_out, st_ut_out, st_ton_max_out,
		st_vin_ov_out, st_vin_uv_out})) else $error("alert level wrong");
	a_ot_status: assert property (
		|ot_fault_in |=> (st_ot_out & $past(ot_fault_in)) ==
		$past(ot_fault_in)) else $error("ot status not set");
	a_ut_status: assert property (
		|ut_fault_in |=> (st_ut_out & $past(ut_fault_in)) ==
		$past(ut_fault_in)) else $error("ut status not set");
	a_vin_status: assert property (
		vin_ov_fault_in || vin_uv_fault_in |=> sum_input_out && sum_high_out)
		else $error("input summary not set");
	a_ton_status: assert property (
		|ton_max_fault_in |=> sum_vout_out && sum_high_out &&
		!host_alert_n_out) else $error("timeout status not set");
	a_temp_sum: assert property (
		sum_temp_out == |{st_ot_out, st_ut_out}) else $error("temp summary");
	a_vout_sum: assert property (
		sum_vout_out == |st_ton_max_out) else $error("vout summary");
	a_clear_alert: assert property (
		cmd_valid_in && cmd_write_in && cmd_code_in == 8'h03 && !any_f
		|=> host_alert_n_out) else $error("clear kept alert");
	a_read_answer: assert property (
		!$past(rst_in) |-> cmd_rvalid_out == $past(rd_req))
		else $error("read answer timing");
endmodule
bind sfr_core sfr_core_props #(.NCH(NCH)) u_sfr_core_props (.*);

// ===== testbench/sfr_share_src.sv
/*
 Shared timing clock of the power system.
 Assumes nothing; runs free from time zero.
*/
`timescale 1ns/1ps
module sfr_share_src (
	output logic share_clk_out
);
	initial begin
		share_clk_out = 1'b0;
		#1.3;
		forever #6 share_clk_out = ~share_clk_out;
	end
endmodule

// ===== testbench/sfr_core_tb_top.sv
/*
 Self-checking bench for the fault response core.
 Assumes the props checker and share clock source compiled first.
*/
`timescale 1ns/1ps
module sfr_core_tb_top;
	logic        mclk_in = 1'b0;
	logic        rst_in, share_clk_in, cmd_valid_in, cmd_write_in, bias_ok_in;
	logic        vin_ov_fault_in, vin_uv_fault_in, cmd_rvalid_out, rv_seen;
	logic        st_vin_ov_out, st_vin_uv_out, sum_temp_out, sum_input_out;
	logic        sum_vout_out, sum_high_out, host_alert_n_out;
	logic [7:0]  cmd_code_in;
	logic [15:0] cmd_wdata_in, cmd_rdata_out, rd_seen;
	logic [1:0]  control_pin_in, op_on_in, track_en_in, ot_fault_in;
	logic [1:0]  ut_fault_in, ton_max_fault_in, chan_en_out, st_ot_out;
	logic [1:0]  st_ut_out, st_ton_max_out;
	int          error_cnt = 0;
	int          comparisons = 0;

	always #2 mclk_in = ~mclk_in;
	sfr_share_src u_sfr_share_src (.share_clk_out(share_clk_in));
	sfr_core #(.NCH(2), .TOFF_CYCLES(32'h0000_0008),
		.SHARE_PER_STEP(16'h0002), .CLEAR_CYCLES(32'h0000_00C8)) u_sfr_core (.*);

	task automatic chk(input string nm, input logic [15:0] e, g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
		cmd_valid_in = 1'b1;
		cmd_write_in = w;
		cmd_code_in = c;
		cmd_wdata_in = d;
		@(negedge mclk_in);
		cmd_valid_in = 1'b0;
		rv_seen = cmd_rvalid_out;
		rd_seen = cmd_rdata_out;
		@(negedge mclk_in);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		cmd(1'b0, c, 16'h0000);
		chk("rvalid", 16'h0001, {15'h0, rv_seen});
		chk("rdata", e, rd_seen);
	endtask
	task automatic wait_en(input int n, input logic [1:0] e);
		for (int i = 0; i < n && chan_en_out !== e; i++)
			@(negedge mclk_in);
		chk("chan_en", {14'h0, e}, {14'h0, chan_en_out});
	endtask
	task automatic pin_cycle;
		control_pin_in = 2'b10;
		repeat (4) @(negedge mclk_in);
		control_pin_in = 2'b11;
		wait_en(10, 2'b11);
	endtask
	task automatic t_regs;
		logic [7:0] codes [6] = '{8'h50, 8'h54, 8'h56, 8'h5A, 8'h63, 8'h77};
		foreach (codes[i]) rd(codes[i], 16'h0000);
		rd(8'hDB, 16'hF320);
		cmd(1'b1, 8'h50, 16'h00FF);
		rd(8'h50, 16'h00F8);
		cmd(1'b1, 8'hDB, 16'hD123);
		rd(8'hDB, 16'hD123);
		cmd(1'b1, 8'hF7, 16'h00FF);
		rd(8'hF7, 16'h0007);
		cmd(1'b1, 8'h50, 16'h0000);
	endtask
	task automatic t_noact;
		wait_en(10, 2'b11);
		{ot_fault_in, ut_fault_in, ton_max_fault_in} = 6'h3F;
		{vin_ov_fault_in, vin_uv_fault_in} = 2'b11;
		@(negedge mclk_in);
		{ot_fault_in, ut_fault_in, ton_max_fault_in} = 6'h00;
		{vin_ov_fault_in, vin_uv_fault_in} = 2'b00;
		chk("status", 16'h03FF, {6'h0, st_ot_out, st_ut_out, st_ton_max_out,
			st_vin_ov_out, st_vin_uv_out, sum_temp_out, sum_input_out});
		chk("alert_n", 16'h0000, {15'h0, host_alert_n_out});
		wait_en(1, 2'b11);
		cmd(1'b1, 8'h03, 16'h0000);
		chk("st_ot", 16'h0000, {14'h0, st_ot_out});
		chk("alert_n", 16'h0001, {15'h0, host_alert_n_out});
	endtask
	task automatic t_latch;
		cmd(1'b1, 8'h54, 16'h0040);
		ut_fault_in = 2'b01;
		@(negedge mclk_in);
		ut_fault_in = 2'b00;
		wait_en(1, 2'b10);
		repeat (100) @(negedge mclk_in);
		cmd(1'b1, 8'h03, 16'h0000);
		repeat (5) @(negedge mclk_in);
		wait_en(1, 2'b10);
		pin_cycle();
	endtask
	task automatic t_track;
		track_en_in = 2'b01;
		cmd(1'b1, 8'h50, 16'h0080);
		ot_fault_in = 2'b01;
		@(negedge mclk_in);
		ot_fault_in = 2'b00;
		repeat (4) @(negedge mclk_in);
		wait_en(1, 2'b11);
		wait_en(10, 2'b10);
		op_on_in = 2'b10;
		repeat (4) @(negedge mclk_in);
		op_on_in = 2'b11;
		wait_en(10, 2'b11);
		track_en_in = 2'b00;
	endtask
	task automatic t_retry;
		cmd(1'b1, 8'hDB, 16'h0001);
		cmd(1'b1, 8'hF7, 16'h0001);
		cmd(1'b1, 8'h63, 16'h0048);
		ton_max_fault_in = 2'b01;
		@(negedge mclk_in);
		ton_max_fault_in = 2'b00;
		wait_en(1, 2'b10);
		repeat (20) @(negedge mclk_in);
		wait_en(1, 2'b10);
		wait_en(60, 2'b11);
		ton_max_fault_in = 2'b01;
		@(negedge mclk_in);
		ton_max_fault_in = 2'b00;
		wait_en(1, 2'b10);
		repeat (300) @(negedge mclk_in);
		wait_en(1, 2'b10);
		pin_cycle();
	endtask
	task automatic end_sim;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#40000;
		error_cnt++;
		end_sim();
	end
	initial begin
		{cmd_valid_in, cmd_write_in, cmd_code_in, cmd_wdata_in} = '0;
		{ot_fault_in, ut_fault_in, ton_max_fault_in, track_en_in} = '0;
		{vin_ov_fault_in, vin_uv_fault_in} = 2'b00;
		control_pin_in = 2'b11;
		op_on_in = 2'b11;
		bias_ok_in = 1'b1;
		rst_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		rst_in = 1'b0;
		t_regs();
		t_noact();
		t_latch();
		t_track();
		t_retry();
		end_sim();
	end
endmodule
